// ===== steer_fb_regs.svh
// Register offsets, field positions, reset values and timing counts for steer position feedback
`ifndef STEER_FB_REGS_SVH
`define STEER_FB_REGS_SVH
// Byte offsets on the register bus
`define FB_CTRL_ADR    8'h00
`define FB_LEFT_ADR    8'h04
`define FB_CENTER_ADR  8'h08
`define FB_RIGHT_ADR   8'h0c
`define FB_FMIN_ADR    8'h10
`define FB_FMAX_ADR    8'h14
`define FB_LSTOP_ADR   8'h18
`define FB_RSTOP_ADR   8'h1c
`define FB_STEPS_ADR   8'h20
`define FB_OFFSET_ADR  8'h24
`define FB_STATUS_ADR  8'h28
`define FB_MASK_ADR    8'h2c
`define FB_POS_ADR     8'h30
`define FB_ANGLE_ADR   8'h34
// Control fields
`define FB_TYPE_LSB    0
`define FB_REDUND_BIT  2
`define FB_SWAP_BIT    3
`define FB_CHECK_BIT   4
// Status and mask layout
`define FB_ST_W        7
`define FB_ST_ENC_LSB  4
`define FB_ST_HOME_BIT 6
// Reset values
`define FB_CTRL_RST    5'h00
`define FB_LEFT_RST    13'h01f4
`define FB_CENTER_RST  13'h09c4
`define FB_RIGHT_RST   13'h1194
`define FB_FMIN_RST    13'h00c8
`define FB_FMAX_RST    13'h12c0
`define FB_LSTOP_RST   16'hfc7c
`define FB_RSTOP_RST   16'h0384
`define FB_STEPS_RST   12'h280
`define FB_OFFSET_RST  16'h0000
`define FB_MASK_RST    7'h00
// Limits of settable values
`define FB_VOLT_MAX    13'h1388
`define FB_STEPS_MIN   12'h014
`define FB_STEPS_MAX   12'ha00
`define FB_OFFSET_MAX  16'h0708
// Encoder residue added per counted event, tenths of a degree times steps; edges counted before an open phase is flagged
`define FB_QUAD_INC    20'sh02328
`define FB_POL_INC     20'sh08ca0
`define FB_OPEN_EDGES  3'h4
// Timing
`define FB_CLK_HZ      200000000
`define FB_FAULT_MS    60
`define FB_FAULT_CYC   ((`FB_CLK_HZ / 1000) * `FB_FAULT_MS)
`endif

// ===== steer_fb_pkg.sv
// Types shared by the steer position feedback logic
package steer_fb_pkg;
  typedef enum logic [1:0] {
    FB_ANALOG   = 2'h0,
    FB_POLARITY = 2'h1,
    FB_QUAD     = 2'h2
  } fb_type_t;
  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_RUN  = 3'b010,
    DIV_DONE = 3'b100
  } div_state_t;
endpackage

// ===== steer_position_feedback.sv
// Steered-wheel position feedback: analog map, window faults, encoder scaling, homing zero
// Overview of operation
// - Redundancy off reads primary only, on both
// - Left, centre, right voltages held, 0-5 V
// - Voltage maps to stop angles, centre zero
// - Map slope may run either way
// - Fault after 60 ms below minimum
// - Fault after 60 ms above maximum
// - Encoder scaled by pulses per rev, 2-256
// - Direction swap inverts encoder sign
// - Encoder check only for quadrature type
// - Detect single open phase line A or B
// - Zero equals home plus signed centre offset
// - Encoder positions referenced to offset-adjusted zero
// - Type selects analog, polarity or quadrature
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "steer_fb_regs.svh"

module steer_position_feedback
  import steer_fb_pkg::*;
#(
  parameter int unsigned FAULT_CYCLES = `FB_FAULT_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic [12:0] i_pos1_mv,
  input  wire logic [12:0] i_pos2_mv,
  input  wire logic        i_adc_valid,
  input  wire logic        i_enc_a,
  input  wire logic        i_enc_b,
  input  wire logic        i_home_done,
  output logic      [23:0] o_wheel_pos,
  output logic             o_fault,
  output logic             o_irq
);
  localparam logic [23:0] FLT_N = 24'(FAULT_CYCLES);

  logic [4:0]                ctrl;
  logic [12:0]               cal_left;
  logic [12:0]               cal_center;
  logic [12:0]               cal_right;
  logic [12:0]               flt_min;
  logic [12:0]               flt_max;
  logic signed [15:0]        stop_left;
  logic signed [15:0]        stop_right;
  logic signed [15:0]        ctr_offset;
  logic [11:0]               enc_steps;
  logic [`FB_ST_W-1:0]       status;
  logic [`FB_ST_W-1:0]       irq_mask;
  logic [31:0]               rdata;
  logic signed [23:0]        angle;
  logic signed [23:0]        zero;

  // Bus decode; a request is taken once, the cycle before ack
  wire        bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire        bus_wr  = bus_req & i_wb_we;
  wire [31:0] lane    = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wdat    = i_wb_dat & lane;
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~lane) | wdat;
  endfunction
  // Out-of-range settings are pinned so the datapath never sees them
  function automatic logic [12:0] lim_mv(input logic [31:0] v);
    lim_mv = (v > {19'h0, `FB_VOLT_MAX}) ? `FB_VOLT_MAX : v[12:0];
  endfunction
  function automatic logic [11:0] lim_steps(input logic [31:0] v);
    if (v < {20'h0, `FB_STEPS_MIN}) lim_steps = `FB_STEPS_MIN;
    else if (v > {20'h0, `FB_STEPS_MAX}) lim_steps = `FB_STEPS_MAX;
    else lim_steps = v[11:0];
  endfunction
  function automatic logic [15:0] lim_off(input logic [31:0] v);
    logic signed [15:0] s;
    s = $signed(v[15:0]);
    if (s > $signed(`FB_OFFSET_MAX)) lim_off = `FB_OFFSET_MAX;
    else if (s < -$signed(`FB_OFFSET_MAX)) lim_off = 16'(-$signed(`FB_OFFSET_MAX));
    else lim_off = v[15:0];
  endfunction
  // Configuration registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl       <= `FB_CTRL_RST;
      cal_left   <= `FB_LEFT_RST;
      cal_center <= `FB_CENTER_RST;
      cal_right  <= `FB_RIGHT_RST;
      flt_min    <= `FB_FMIN_RST;
      flt_max    <= `FB_FMAX_RST;
      stop_left  <= `FB_LSTOP_RST;
      stop_right <= `FB_RSTOP_RST;
      enc_steps  <= `FB_STEPS_RST;
      ctr_offset <= `FB_OFFSET_RST;
      irq_mask   <= `FB_MASK_RST;
    end else if (bus_wr) begin
      case (i_wb_adr)
        `FB_CTRL_ADR:   ctrl       <= 5'(merge({27'h0, ctrl}));
        `FB_LEFT_ADR:   cal_left   <= lim_mv(merge({19'h0, cal_left}));
        `FB_CENTER_ADR: cal_center <= lim_mv(merge({19'h0, cal_center}));
        `FB_RIGHT_ADR:  cal_right  <= lim_mv(merge({19'h0, cal_right}));
        `FB_FMIN_ADR:   flt_min    <= lim_mv(merge({19'h0, flt_min}));
        `FB_FMAX_ADR:   flt_max    <= lim_mv(merge({19'h0, flt_max}));
        `FB_LSTOP_ADR:  stop_left  <= 16'(merge({16'h0, stop_left}));
        `FB_RSTOP_ADR:  stop_right <= 16'(merge({16'h0, stop_right}));
        `FB_STEPS_ADR:  enc_steps  <= lim_steps(merge({20'h0, enc_steps}));
        `FB_OFFSET_ADR: ctr_offset <= lim_off(merge({16'h0, ctr_offset}));
        `FB_MASK_ADR:   irq_mask   <= 7'(merge({25'h0, irq_mask}));
        default:        ctrl       <= ctrl;
      endcase
    end
  end
  // Control field decode
  fb_type_t fb_type;
  assign fb_type = fb_type_t'(ctrl[`FB_TYPE_LSB +: 2]);
  wire is_analog = fb_type == FB_ANALOG;
  wire is_quad   = fb_type == FB_QUAD;
  wire is_pol    = fb_type == FB_POLARITY;
  wire redund    = ctrl[`FB_REDUND_BIT];
  wire swap      = ctrl[`FB_SWAP_BIT];
  wire chk_on    = is_quad & ctrl[`FB_CHECK_BIT];
  // Samples start at centre, so no window count runs before the first conversion
  logic [12:0] smp1;
  logic [12:0] smp2;
  logic        smp_new;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp1    <= `FB_CENTER_RST;
      smp2    <= `FB_CENTER_RST;
      smp_new <= 1'b0;
    end else begin
      smp_new <= i_adc_valid & is_analog;
      if (i_adc_valid) smp1 <= i_pos1_mv;
      if (i_adc_valid && redund) smp2 <= i_pos2_mv;
    end
  end
  // Window checks: index 0/1 primary low/high, 2/3 secondary low/high
  logic [3:0] flt_evt;
  logic [3:0] flt_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_win
      wire [12:0]  s      = (gi < 2) ? smp1 : smp2;
      wire         active = is_analog & ((gi < 2) | redund);
      wire         lo     = s < flt_min;
      wire         hi     = s > flt_max;
      wire         cond   = active & (((gi % 2) == 0) ? lo : hi);
      logic [23:0] cnt;
      // Any sample back inside the window restarts the count
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) cnt <= 24'h0;
        else if (!cond) cnt <= 24'h0;
        else if (cnt != FLT_N) cnt <= cnt + 24'h1;
      end
      assign flt_evt[gi] = cond & (cnt == FLT_N - 24'h1);
      assign flt_lvl[gi] = cnt == FLT_N;
    end
  endgenerate
  // Segment choice by sign lets either end voltage be the higher one
  wire signed [13:0] d_v   = $signed({1'b0, smp1}) - $signed({1'b0, cal_center});
  wire signed [13:0] d_r   = $signed({1'b0, cal_right}) - $signed({1'b0, cal_center});
  wire signed [13:0] d_l   = $signed({1'b0, cal_left}) - $signed({1'b0, cal_center});
  wire               side_r = d_v[13] == d_r[13];
  wire signed [13:0] d_e   = side_r ? d_r : d_l;
  wire signed [15:0] stop  = side_r ? stop_right : stop_left;
  wire [12:0]        abs_v = d_v[13] ? 13'(-d_v) : d_v[12:0];
  wire [12:0]        abs_e = d_e[13] ? 13'(-d_e) : d_e[12:0];
  wire [14:0]        abs_s = stop[15] ? 15'(-stop) : stop[14:0];
  wire               clamp = (abs_v >= abs_e) && (abs_v != 13'h0);
  wire [27:0]        num   = abs_v * abs_s;
  // Restoring divider, one quotient bit per clock; a sample during a run is skipped
  div_state_t         dstate;
  logic [27:0]        quo;
  logic [13:0]        rem;
  logic [12:0]        den;
  logic [4:0]         dcnt;
  logic               dneg;
  logic signed [15:0] ana_pos;
  wire [13:0]         rem_sh = {rem[12:0], quo[27]};
  wire                rem_ge = rem_sh >= {1'b0, den};
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dstate  <= DIV_IDLE;
      quo     <= 28'h0;
      rem     <= 14'h0;
      den     <= 13'h0;
      dcnt    <= 5'h0;
      dneg    <= 1'b0;
      ana_pos <= 16'sh0;
    end else begin
      case (dstate)
        DIV_IDLE: begin
          if (smp_new && clamp) begin
            ana_pos <= stop;
          end else if (smp_new) begin
            quo    <= num;
            rem    <= 14'h0;
            den    <= abs_e;
            dneg   <= stop[15];
            dcnt   <= 5'h1b;
            dstate <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          quo  <= {quo[26:0], rem_ge};
          rem  <= rem_ge ? rem_sh - {1'b0, den} : rem_sh;
          dcnt <= dcnt - 5'h1;
          if (dcnt == 5'h0) dstate <= DIV_DONE;
        end
        DIV_DONE: begin
          ana_pos <= dneg ? 16'(-quo[15:0]) : quo[15:0];
          dstate  <= DIV_IDLE;
        end
        default: dstate <= DIV_IDLE;
      endcase
    end
  end
  // Encoder pins pass two flops; a third holds the previous level for edges
  logic a_s1;
  logic a_s2;
  logic a_q;
  logic b_s1;
  logic b_s2;
  logic b_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {a_s1, a_s2, a_q} <= 3'h0;
      {b_s1, b_s2, b_q} <= 3'h0;
    end else begin
      {a_s1, a_s2, a_q} <= {i_enc_a, a_s1, a_s2};
      {b_s1, b_s2, b_q} <= {i_enc_b, b_s1, b_s2};
    end
  end
  wire a_edge = a_s2 ^ a_q;
  wire b_edge = b_s2 ^ b_q;
  // Both phases moving at once is illegal in quadrature and is not counted
  wire q_step = is_quad & (a_edge ^ b_edge);
  wire p_step = is_pol & a_edge & a_s2;
  wire dir_up = (is_quad ? (a_s2 ^ b_q) : b_s2) ^ swap;
  // Residue scaling avoids a divider; it drains one degree tenth per clock
  logic signed [19:0] resid;
  wire signed [19:0]  inc   = is_quad ? `FB_QUAD_INC : `FB_POL_INC;
  wire signed [19:0]  r_add = resid + ((q_step | p_step) ? (dir_up ? inc : -inc) : 20'sh0);
  wire signed [19:0]  stp   = $signed({8'h0, enc_steps});
  wire                r_up  = r_add >= stp;
  wire                r_dn  = r_add <= -stp;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resid <= 20'sh0;
      angle <= 24'sh0;
    end else begin
      resid <= r_up ? r_add - stp : (r_dn ? r_add + stp : r_add);
      if (r_up) angle <= angle + 24'sh1;
      else if (r_dn) angle <= angle - 24'sh1;
    end
  end
  // Homing captures the zero; later positions are taken against it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) zero <= 24'sh0;
    else if (i_home_done) zero <= angle + {{8{ctr_offset[15]}}, ctr_offset};
  end
  wire signed [23:0] enc_pos = angle - zero;
  // Open phase: one line keeps toggling while the other stays still
  wire [1:0] ph_edge = {b_edge, a_edge};
  logic [1:0] open_evt;
  genvar gj;
  generate
    for (gj = 0; gj < 2; gj++) begin : g_open
      logic [2:0] run;
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) run <= 3'h0;
        else if (!chk_on || ph_edge[1-gj]) run <= 3'h0;
        else if (ph_edge[gj] && run != `FB_OPEN_EDGES) run <= run + 3'h1;
      end
      assign open_evt[gj] = chk_on & ph_edge[gj] & ~ph_edge[1-gj]
                          & (run == `FB_OPEN_EDGES - 3'h1);
    end
  endgenerate
  // Sticky status; an event in the clearing cycle survives
  wire [`FB_ST_W-1:0] evt         = {i_home_done, open_evt, flt_evt};
  wire                st_wr       = bus_wr & (i_wb_adr == `FB_STATUS_ADR);
  wire [`FB_ST_W-1:0] st_clr      = st_wr ? wdat[`FB_ST_W-1:0] : 7'h00;
  wire [`FB_ST_W-1:0] next_status = (status & ~st_clr) | evt;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status      <= 7'h00;
      o_irq       <= 1'b0;
      o_fault     <= 1'b0;
      o_wheel_pos <= 24'h0;
    end else begin
      status      <= next_status;
      o_irq       <= |(next_status & irq_mask);
      o_fault     <= (|flt_lvl) | (|next_status[`FB_ST_ENC_LSB +: 2]);
      o_wheel_pos <= is_analog ? {{8{ana_pos[15]}}, ana_pos} : enc_pos;
    end
  end
  // Read selection; unmapped offsets read zero
  always_comb begin
    case (i_wb_adr)
      `FB_CTRL_ADR:   rdata = {27'h0, ctrl};
      `FB_LEFT_ADR:   rdata = {19'h0, cal_left};
      `FB_CENTER_ADR: rdata = {19'h0, cal_center};
      `FB_RIGHT_ADR:  rdata = {19'h0, cal_right};
      `FB_FMIN_ADR:   rdata = {19'h0, flt_min};
      `FB_FMAX_ADR:   rdata = {19'h0, flt_max};
      `FB_LSTOP_ADR:  rdata = {{16{stop_left[15]}}, stop_left};
      `FB_RSTOP_ADR:  rdata = {{16{stop_right[15]}}, stop_right};
      `FB_STEPS_ADR:  rdata = {20'h0, enc_steps};
      `FB_OFFSET_ADR: rdata = {{16{ctr_offset[15]}}, ctr_offset};
      `FB_STATUS_ADR: rdata = {25'h0, status};
      `FB_MASK_ADR:   rdata = {25'h0, irq_mask};
      `FB_POS_ADR:    rdata = {{8{o_wheel_pos[23]}}, o_wheel_pos};
      `FB_ANGLE_ADR:  rdata = {{8{angle[23]}}, angle};
      default:        rdata = 32'h0;
    endcase
  end
  // Every access, mapped or not, is answered one cycle after it is seen
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req) o_wb_dat <= rdata;
    end
  end
endmodule
`default_nettype wire

// ===== steer_fb_assertions.sv
// Concurrent checks on the ports of the steer position feedback block
`timescale 1ns/1ps
`default_nettype none
`include "steer_fb_regs.svh"

module steer_fb_assertions #(
  parameter int unsigned FAULT_CYCLES = 20
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [12:0] i_pos1_mv,
  input wire logic [12:0] i_pos2_mv,
  input wire logic        i_adc_valid,
  input wire logic        i_enc_a,
  input wire logic        i_enc_b,
  input wire logic        i_home_done,
  input wire logic [23:0] o_wheel_pos,
  input wire logic        o_fault,
  input wire logic        o_irq
);
  logic [11:0] quiet;
  logic [31:0] since;
  wire  logic  req = i_wb_cyc && i_wb_stb;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Quiet time covers the worst encoder drain of 1800 clocks plus sync lag
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quiet <= 12'h000;
      since <= 32'h0;
    end else begin
      quiet <= (i_adc_valid || i_home_done || i_wb_cyc || $changed({i_enc_a, i_enc_b})) ?
               12'h000 : ((quiet == 12'hfff) ? quiet : quiet + 12'h001);
      since <= (since == 32'hffffffff) ? since : since + 32'h1;
    end
  end

  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_answer: assert property ((req && !o_wb_ack) |=> o_wb_ack) else $error("ack late");
  a_ack_cause: assert property (!req |=> !o_wb_ack) else $error("ack without request");
  a_rdata_hold: assert property ($changed(o_wb_dat) |-> o_wb_ack) else $error("read data moved");
  a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (1'b0)
    !i_rst_n |-> !o_wb_ack && !o_fault && !o_irq && o_wheel_pos == 24'h0)
    else $error("outputs active in reset");
  a_release_quiet: assert property ($rose(i_rst_n) |-> (!o_irq && !o_fault) [*2])
    else $error("flags active right after reset");
  a_irq_mask_off: assert property ((req && i_wb_we && !o_wb_ack && i_wb_sel[0] &&
    i_wb_adr == `FB_MASK_ADR && i_wb_dat[6:0] == 7'h00) |-> ##2 !o_irq)
    else $error("irq with empty mask");
  a_pos_quiet: assert property (quiet > 12'h7f8 |-> $stable(o_wheel_pos))
    else $error("position moved with no cause");
  a_fault_window: assert property ($rose(o_fault) |-> since >= FAULT_CYCLES)
    else $error("fault before window elapsed");

  c_ack: cover property (o_wb_ack);
  c_fault: cover property ($rose(o_fault));
  c_irq: cover property ($rose(o_irq));
endmodule

bind steer_position_feedback steer_fb_assertions #(.FAULT_CYCLES(FAULT_CYCLES)) u_chk (
  .i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_pos1_mv, .i_pos2_mv, .i_adc_valid, .i_enc_a, .i_enc_b,
  .i_home_done, .o_wheel_pos, .o_fault, .o_irq);
`default_nettype wire

// ===== steer_sensor_model.sv
// Behavioural position sensor: wiper pots with a sampling converter, and an encoder
`timescale 1ns/1ps
`default_nettype none

module steer_sensor_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_run,
  input  wire logic [12:0] i_v1,
  input  wire logic [12:0] i_v2,
  input  wire logic        i_step,
  input  wire logic        i_dir,
  input  wire logic        i_pol,
  input  wire logic        i_open_b,
  output logic      [12:0] o_pos1_mv,
  output logic      [12:0] o_pos2_mv,
  output logic             o_adc_valid,
  output logic             o_enc_a,
  output logic             o_enc_b
);
  logic [5:0] tick;
  logic [1:0] ph;
  logic [3:0] pw;

  // One conversion every 64 clocks, so the divider is idle for each sample
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick <= 6'h00;
      o_adc_valid <= 1'b0;
      o_pos1_mv <= 13'h09c4;
      o_pos2_mv <= 13'h09c4;
    end else begin
      tick <= tick + 6'h01;
      o_adc_valid <= i_run && (tick == 6'h3f);
      o_pos1_mv <= (tick == 6'h3f) ? i_v1 : o_pos1_mv;
      o_pos2_mv <= (tick == 6'h3f) ? i_v2 : o_pos2_mv;
    end
  end

  // Gray phase counter for quadrature, pulse stretcher for polarity mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph <= 2'h0;
      pw <= 4'h0;
    end else begin
      ph <= (i_step && !i_pol) ? (i_dir ? ph + 2'h1 : ph - 2'h1) : ph;
      pw <= (i_step && i_pol) ? 4'h8 : ((pw == 4'h0) ? pw : pw - 4'h1);
    end
  end

  assign o_enc_a = i_pol ? (pw != 4'h0) : (ph[0] ^ ph[1]);
  // An open phase line floats up to its pull-up level
  assign o_enc_b = i_open_b ? 1'b1 : (i_pol ? i_dir : ph[1]);
endmodule
`default_nettype wire

// ===== test_steer_position_feedback.sv
// Self-checking bench for the steer position feedback block
`timescale 1ns/1ps
`default_nettype none
`include "steer_fb_regs.svh"

module test_steer_position_feedback;
  logic        clk, rst_n, cyc, stb, we, run, step, dir, pol, open_b, home;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, r;
  logic [12:0] v1, v2;
  wire  logic [31:0] rdat;
  wire  logic        ack, fault, irq, adcv, ea, eb;
  wire  logic [23:0] pos;
  wire  logic [12:0] p1, p2;
  wire  logic [31:0] pos32 = {{8{pos[23]}}, pos};
  int mismatches, tests_run, i, v, stp, off, a1;
  localparam logic [15:0] RV [12] = '{`FB_CTRL_RST, `FB_LEFT_RST, `FB_CENTER_RST,
    `FB_RIGHT_RST, `FB_FMIN_RST, `FB_FMAX_RST, `FB_LSTOP_RST, `FB_RSTOP_RST,
    `FB_STEPS_RST, `FB_OFFSET_RST, 16'h0000, `FB_MASK_RST};

  steer_position_feedback #(.FAULT_CYCLES(20)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pos1_mv(p1), .i_pos2_mv(p2),
    .i_adc_valid(adcv), .i_enc_a(ea), .i_enc_b(eb), .i_home_done(home),
    .o_wheel_pos(pos), .o_fault(fault), .o_irq(irq));
  steer_sensor_model sensor (.i_ref_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_v1(v1),
    .i_v2(v2), .i_step(step), .i_dir(dir), .i_pol(pol), .i_open_b(open_b),
    .o_pos1_mv(p1), .o_pos2_mv(p2), .o_adc_valid(adcv), .o_enc_a(ea), .o_enc_b(eb));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Single Wishbone cycle; waits for ack, only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle homing pulse, then time for the zero to reach the output
  task automatic homing;
    @(posedge clk);
    home <= 1'b1;
    @(posedge clk);
    home <= 1'b0;
    wait_clk(4);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    wait_clk(6);
    rst_n <= 1'b1;
  endtask

  // Gap keeps each counted pulse clear of the residue drain time
  task automatic steps(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      wait_clk(gap);
    end
  endtask

  // Three-point map, truncated toward zero, clamped at the stops
  function automatic int exp_map(int v, int l, int c, int rt, int ls, int rs);
    int n;
    int d;
    int s;
    n = v - c;
    d = ((n < 0) == (rt - c < 0)) ? rt - c : l - c;
    s = ((n < 0) == (rt - c < 0)) ? rs : ls;
    if ((n < 0 ? -n : n) >= (d < 0 ? -d : d)) return s;
    return s * n / d;
  endfunction

  function automatic int exp_enc(int n, int inc, int stp, int neg);
    return neg ? -(n * inc / stp) : n * inc / stp;
  endfunction

  task automatic enc(input int typ, input int s, input int sw, input int n, input int d);
    pol <= (typ == 1);
    dir <= d[0];
    bus(1'b1, `FB_CTRL_ADR, typ | (sw << 3));
    bus(1'b1, `FB_STEPS_ADR, s);
    steps(n, 1900);
    chk(pos32, exp_enc(n, (typ == 2) ? 9000 : 36000, s, d == sw));
  endtask

  task automatic final_report;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(95000 * 5);
    mismatches++;
    final_report();
  end

  initial begin
    {rst_n, cyc, stb, we, step, dir, pol, open_b, home} = 9'h000;
    {adr, dat, sel, run, v1, v2} = {8'h00, 32'h0, 4'hf, 1'b1, 13'h09c4, 13'h09c4};
    mismatches = 0;
    tests_run = 0;
    void'($urandom(18730));
    do_reset();
    for (i = 0; i < 12; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk({16'h0000, r[15:0]}, {16'h0000, RV[i]});
    end
    bus(1'b1, `FB_LEFT_ADR, 32'h1f40);
    bus(1'b0, `FB_LEFT_ADR, 32'h0);
    chk(r, 32'h1388);
    bus(1'b1, `FB_LEFT_ADR, 32'h01f4);
    bus(1'b1, `FB_STEPS_ADR, 32'h5);
    bus(1'b0, `FB_STEPS_ADR, 32'h0);
    chk(r, 32'h14);
    bus(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    $display("test registers done");
    // Analog map: both slopes, fixed corners then random voltages
    for (i = 0; i < 12; i++) begin
      if (i == 8) bus(1'b1, `FB_LEFT_ADR, 32'd4000);
      if (i == 8) bus(1'b1, `FB_RIGHT_ADR, 32'd800);
      if (i == 8) bus(1'b1, `FB_CENTER_ADR, 32'd2000);
      v = (i < 4) ? (i * 1250 + (i == 1) * 250) : $urandom_range(5000);
      v1 <= v[12:0];
      wait_clk(160);
      if (i < 8) chk(pos32, exp_map(v, 500, 2500, 4500, -900, 900));
      else chk(pos32, exp_map(v, 4000, 2000, 800, -900, 900));
    end
    $display("test analog map done");
    v1 <= 13'd2500;
    do_reset();
    v1 <= 13'd100;
    wait_clk(200);
    chk({31'h0, fault}, 32'h1);
    bus(1'b0, `FB_STATUS_ADR, 32'h0);
    chk(r, 32'h1);
    v1 <= 13'd2500;
    wait_clk(200);
    chk({31'h0, fault}, 32'h0);
    bus(1'b1, `FB_MASK_ADR, 32'h1);
    wait_clk(3);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `FB_STATUS_ADR, 32'h1);
    wait_clk(3);
    chk({31'h0, irq}, 32'h0);
    v1 <= 13'd4900;
    wait_clk(200);
    bus(1'b0, `FB_STATUS_ADR, 32'h0);
    chk(r, 32'h2);
    chk({31'h0, irq}, 32'h0);
    v1 <= 13'd2500;
    v2 <= 13'd0;
    wait_clk(100);
    bus(1'b1, `FB_MASK_ADR, 32'h0);
    bus(1'b1, `FB_STATUS_ADR, 32'h2);
    wait_clk(200);
    chk({31'h0, fault}, 32'h0);
    bus(1'b1, `FB_CTRL_ADR, 32'h4);
    wait_clk(200);
    chk({31'h0, fault}, 32'h1);
    bus(1'b0, `FB_STATUS_ADR, 32'h0);
    chk(r, 32'h4);
    $display("test window fault done");
    // Encoder runs with the converter idle so the position only follows pulses
    run <= 1'b0;
    v2 <= 13'd2500;
    do_reset();
    enc(2, 20, 0, 6, 1);
    homing();
    chk(pos32, 32'h0);
    do_reset();
    enc(2, 2560, 1, 6, 1);
    do_reset();
    stp = 20 + $urandom_range(2540);
    enc(1, stp, 0, 4, 1);
    a1 = 4 * 36000 / stp;
    off = $urandom_range(3600) - 1800;
    bus(1'b1, `FB_OFFSET_ADR, off);
    homing();
    chk(pos32, -off);
    bus(1'b0, `FB_STATUS_ADR, 32'h0);
    chk(r & 32'h40, 32'h40);
    steps(2, 1900);
    chk(pos32, 6 * 36000 / stp - a1 - off);
    bus(1'b0, `FB_POS_ADR, 32'h0);
    chk(r, 6 * 36000 / stp - a1 - off);
    bus(1'b0, `FB_ANGLE_ADR, 32'h0);
    chk(r, 6 * 36000 / stp);
    wait_clk(2100);
    $display("test encoder and homing done");
    do_reset();
    open_b <= 1'b1;
    pol <= 1'b0;
    bus(1'b1, `FB_CTRL_ADR, 32'h12);
    steps(8, 200);
    chk({31'h0, fault}, 32'h1);
    bus(1'b0, `FB_STATUS_ADR, 32'h0);
    chk(r, 32'h10);
    do_reset();
    pol <= 1'b1;
    bus(1'b1, `FB_CTRL_ADR, 32'h11);
    steps(8, 200);
    chk({31'h0, fault}, 32'h0);
    open_b <= 1'b0;
    $display("test open phase done");
    final_report();
  end
endmodule
`default_nettype wire
